// >>> hpq_crc32.sv
// Byte-serial reflected CRC-32 engine for frame check sequences and hashing.
// Assumes data bytes arrive least significant bit first on the same clock.
`timescale 1ns/1ps
module hpq_crc32 (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic clear_i,
    input wire logic en_i,
    input wire logic [7:0] data_i,
    output logic [31:0] crc_o,
    output logic [31:0] crc_nxt_o
);
    import hpq_pkg::*;

    function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
        end
        return r;
    endfunction : crc_byte

    assign crc_nxt_o = crc_byte(crc_o, data_i);

    always_ff @(posedge clock_i) begin
        if (rst_i || clear_i) begin
            crc_o <= CRC_INIT;
        end else if (en_i) begin
            crc_o <= crc_nxt_o;
        end
    end

endmodule : hpq_crc32

// >>> hpq_host_model.sv
// Host-side partner: feeds transmit frames into the block and sinks its transmit output.
// Assumes the bench pulses start_i for one cycle with len_i and id_i held stable.
`timescale 1ns/1ps
module hpq_host_model (
    input wire logic clock_i,
    input wire logic start_i,
    input wire logic [7:0] len_i,
    input wire logic [5:0] id_i,
    input wire logic stall_i,
    input wire logic tx_in_ready_i,
    input wire logic tx_out_valid_i,
    input wire logic tx_out_last_i,
    output logic tx_in_valid_o = 1'b0,
    output logic [7:0] tx_in_data_o,
    output logic tx_in_last_o,
    output logic [5:0] tx_in_id_o,
    output logic tx_out_ready_o,
    output logic [7:0] out_cnt_o = 8'h00,
    output logic done_o = 1'b0
);
    logic [7:0] sent_r = 8'h00;
    logic tog_r = 1'b0;
    // Idle data lines carry a changing pattern and idle id lines the inverted id, so stale data is never mistaken for a byte.
    assign tx_in_last_o = tx_in_valid_o && (sent_r == len_i - 8'h01);
    assign tx_in_data_o = tx_in_valid_o ? sent_r + 8'h11 : {8{tog_r}} ^ 8'h5a;
    assign tx_in_id_o = tx_in_valid_o ? id_i : ~id_i;
    assign tx_out_ready_o = !(stall_i && tog_r);
    always @(posedge clock_i) begin
        tog_r <= !tog_r;
        if (start_i) begin
            tx_in_valid_o <= 1'b1;
            sent_r <= 8'h00;
            out_cnt_o <= 8'h00;
            done_o <= 1'b0;
        end else begin
            if (tx_in_valid_o && tx_in_ready_i) begin
                sent_r <= sent_r + 8'h01;
                if (tx_in_last_o) begin
                    tx_in_valid_o <= 1'b0;
                end
            end
            if (tx_out_valid_i && tx_out_ready_o) begin
                out_cnt_o <= out_cnt_o + 8'h01;
                done_o <= tx_out_last_i;
            end
        end
    end
endmodule : hpq_host_model

// >>> hpq_pkg.sv
// Shared constants and types of the host port queue transmit and receive control.
// Assumes one clock domain and a plain register port with byte offsets.
package hpq_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TX_STAT = 8'h02;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STA_0 = 8'h10;
    localparam logic [7:0] ADDR_STA_1 = 8'h12;
    localparam logic [7:0] ADDR_STA_2 = 8'h14;
    localparam logic [7:0] ADDR_HASH_0 = 8'h18;
    localparam logic [7:0] ADDR_HASH_3 = 8'h1e;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int TXC_RUN = 0;
    localparam int TXC_CRC = 1;
    localparam int TXC_PAD = 2;
    localparam int TXC_PAUSE = 3;
    localparam int RXC_RUN = 0;
    localparam int RXC_HASH = 2;
    localparam int RXC_STRIP = 3;
    localparam int RXC_PROMISC = 4;
    localparam int RXC_UCAST = 5;
    localparam int RXC_MCAST = 6;
    localparam int RXC_BCAST = 7;
    localparam int RXC_ERR = 9;
    localparam int RXC_PAUSE = 10;
    localparam int TXS_ID_W = 6;

    // ------------------------------------------------------------
    // Reset values and writable bit masks
    // ------------------------------------------------------------
    localparam logic [15:0] TX_CTRL_RST = 16'h0000;
    localparam logic [15:0] RX_CTRL_RST = 16'h0000;
    localparam logic [15:0] TX_CTRL_WMASK = 16'h600f;
    localparam logic [15:0] RX_CTRL_WMASK = 16'h06fd;

    // ------------------------------------------------------------
    // Frame layout and timing
    // ------------------------------------------------------------
    localparam int MIN_FRAME_BYTES = 64;
    localparam int CRC_BYTES = 4;
    localparam int DA_BYTES = 6;
    localparam int CLK_PERIOD_NS = 50;
    localparam int QUANTUM_TIME_NS = 5120;
    localparam int QUANTUM_CYC = (QUANTUM_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [31:0] CRC_INIT = 32'hffffffff;
    localparam logic [31:0] CRC_POLY = 32'hedb88320;
    localparam logic [31:0] CRC_RESIDUE = 32'hdebb20e3;

    typedef enum logic [3:0] {
        TX_IDLE = 4'h1,
        TX_DATA = 4'h2,
        TX_PAD = 4'h4,
        TX_FCS = 4'h8
    } hpq_tx_state_type;

endpackage : hpq_pkg

// >>> hpq_txrx_ctrl.sv
// Transmit and receive control of the host port queue: registers, framing and address filter.
// Assumes byte streams on the device clock and a register master that never waits.
//
// Notes on behaviour
// - Transmit pause enable asks for pause frames when the receive FIFO hits threshold while global pause is enabled.
// - Transmit padding enable pads frames shorter than 64 bytes to minimum length.
// - Transmit CRC enable appends a computed CRC to every transmitted frame.
// - Transmit run enable starts transmit; clearing it stops after the current frame.
// - Transmit status bits 5-0 show the identifier of the last transmitted frame.
// - Receive pause honour holds new transmit frames until the pause timer expires.
// - CRC error accept queues bad-CRC frames; otherwise they are all dropped.
// - Broadcast accept takes every broadcast frame.
// - Multicast accept takes every multicast frame, broadcast included.
// - Unicast accept takes frames addressed to the 48-bit station address.
// - Promiscuous mode takes all frames regardless of destination.
// - CRC strip removes received CRC; otherwise CRC is stored after the packet.
// - Hash enable takes multicast frames that pass the CRC hash filter.
// - Receive run enable starts receive; clearing it stops after the current frame.
`timescale 1ns/1ps
module hpq_txrx_ctrl #(
    parameter int QUANTA_W = 16
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [15:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [15:0] reg_rdata_o,
    input wire logic global_pause_en_i,
    input wire logic rx_fifo_threshold_i,
    output logic tx_pause_req_o,
    input wire logic tx_in_valid_i,
    input wire logic [7:0] tx_in_data_i,
    input wire logic tx_in_last_i,
    input wire logic [hpq_pkg::TXS_ID_W-1:0] tx_in_id_i,
    output logic tx_in_ready_o,
    output logic tx_out_valid_o,
    output logic [7:0] tx_out_data_o,
    output logic tx_out_last_o,
    input wire logic tx_out_ready_i,
    input wire logic pause_rx_i,
    input wire logic [QUANTA_W-1:0] pause_quanta_i,
    output logic tx_paused_o,
    input wire logic rx_in_valid_i,
    input wire logic [7:0] rx_in_data_i,
    input wire logic rx_in_last_i,
    output logic rx_out_valid_o,
    output logic [7:0] rx_out_data_o,
    output logic rx_out_last_o,
    output logic rx_out_keep_o
);
    import hpq_pkg::*;

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [15:0] tx_ctrl_r;
    logic [15:0] rx_ctrl_r;
    logic [47:0] station_r;
    logic [63:0] hash_r;
    logic [TXS_ID_W-1:0] last_tx_frame_id_r;
    logic [15:0] rdata_r;
    logic [15:0] rd_val;

    function automatic logic is_hash(input logic [7:0] a);
        return (a >= ADDR_HASH_0) && (a <= ADDR_HASH_3) && !a[0];
    endfunction : is_hash

    wire tx_run_en = tx_ctrl_r[TXC_RUN];
    wire tx_crc_append_en = tx_ctrl_r[TXC_CRC];
    wire tx_pad_en = tx_ctrl_r[TXC_PAD];
    wire tx_pause_gen_en = tx_ctrl_r[TXC_PAUSE];
    wire rx_run_en = rx_ctrl_r[RXC_RUN];
    wire rx_hash_en = rx_ctrl_r[RXC_HASH];
    wire rx_crc_strip = rx_ctrl_r[RXC_STRIP];
    wire rx_promiscuous = rx_ctrl_r[RXC_PROMISC];
    wire rx_unicast_accept = rx_ctrl_r[RXC_UCAST];
    wire rx_multicast_accept = rx_ctrl_r[RXC_MCAST];
    wire rx_broadcast_accept = rx_ctrl_r[RXC_BCAST];
    wire rx_crc_error_accept = rx_ctrl_r[RXC_ERR];
    wire rx_pause_honour_en = rx_ctrl_r[RXC_PAUSE];

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tx_ctrl_r <= TX_CTRL_RST;
            rx_ctrl_r <= RX_CTRL_RST;
            station_r <= '0;
            hash_r <= '0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == ADDR_TX_CTRL) tx_ctrl_r <= reg_wdata_i & TX_CTRL_WMASK;
            if (reg_addr_i == ADDR_RX_CTRL) rx_ctrl_r <= reg_wdata_i & RX_CTRL_WMASK;
            if (reg_addr_i == ADDR_STA_0) station_r[15:0] <= reg_wdata_i;
            if (reg_addr_i == ADDR_STA_1) station_r[31:16] <= reg_wdata_i;
            if (reg_addr_i == ADDR_STA_2) station_r[47:32] <= reg_wdata_i;
            if (is_hash(reg_addr_i)) hash_r[reg_addr_i[2:1]*16 +: 16] <= reg_wdata_i;
        end
    end

    always_comb begin
        rd_val = 16'h0000;
        case (reg_addr_i)
            ADDR_TX_CTRL: rd_val = tx_ctrl_r;
            ADDR_TX_STAT: rd_val = {{(16-TXS_ID_W){1'b0}}, last_tx_frame_id_r};
            ADDR_RX_CTRL: rd_val = rx_ctrl_r;
            ADDR_STA_0: rd_val = station_r[15:0];
            ADDR_STA_1: rd_val = station_r[31:16];
            ADDR_STA_2: rd_val = station_r[47:32];
            default: rd_val = is_hash(reg_addr_i) ? hash_r[reg_addr_i[2:1]*16 +: 16] : 16'h0000;
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) rdata_r <= 16'h0000;
        else rdata_r <= reg_rd_i ? rd_val : 16'h0000;
    end
    assign reg_rdata_o = rdata_r;

    // ------------------------------------------------------------
    // Pause request and pause timer
    // ------------------------------------------------------------
    logic pause_req_r;
    logic [QUANTA_W-1:0] quanta_r;
    logic [7:0] quantum_cnt_r;
    wire pause_active = (quanta_r != '0);

    always_ff @(posedge clock_i) begin
        if (rst_i) pause_req_r <= 1'b0;
        else pause_req_r <= tx_pause_gen_en && global_pause_en_i && rx_fifo_threshold_i;
    end
    assign tx_pause_req_o = pause_req_r;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            quanta_r <= '0;
            quantum_cnt_r <= 8'h00;
        end else if (pause_rx_i && rx_pause_honour_en) begin
            quanta_r <= pause_quanta_i;
            quantum_cnt_r <= 8'h00;
        end else if (pause_active) begin
            if (quantum_cnt_r == 8'(QUANTUM_CYC - 1)) begin
                quantum_cnt_r <= 8'h00;
                quanta_r <= quanta_r - 1'b1;
            end else begin
                quantum_cnt_r <= quantum_cnt_r + 8'h01;
            end
        end
    end
    assign tx_paused_o = pause_active;

    // ------------------------------------------------------------
    // Transmit framing
    // ------------------------------------------------------------
    hpq_tx_state_type tx_st_r;
    logic [6:0] tx_cnt_r;
    logic [1:0] fcs_idx_r;
    logic [TXS_ID_W-1:0] cur_id_r;
    logic txo_valid_r;
    logic [7:0] txo_data_r;
    logic txo_last_r;
    logic [31:0] tx_crc;
    logic [6:0] pad_target;
    logic need_pad;
    wire adv = !txo_valid_r || tx_out_ready_i;
    wire tx_take = tx_in_valid_i && tx_in_ready_o;
    wire tx_start = (tx_st_r == TX_IDLE) && tx_run_en && !pause_active && tx_in_valid_i;
    wire pad_go = (tx_st_r == TX_PAD) && adv;
    wire tx_done = txo_valid_r && txo_last_r && tx_out_ready_i;

    assign tx_in_ready_o = (tx_st_r == TX_DATA) && adv;
    assign pad_target = tx_crc_append_en ? 7'(MIN_FRAME_BYTES - CRC_BYTES) : 7'(MIN_FRAME_BYTES);
    assign need_pad = tx_pad_en && (tx_cnt_r < (pad_target - 7'h01));

    hpq_crc32 u_tx_crc (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clear_i(tx_start),
        .en_i(tx_take || pad_go),
        .data_i(pad_go ? 8'h00 : tx_in_data_i),
        .crc_o(tx_crc),
        .crc_nxt_o()
    );

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            tx_st_r <= TX_IDLE;
        end else begin
            case (tx_st_r)
                TX_IDLE: if (tx_start) tx_st_r <= TX_DATA;
                TX_DATA: if (tx_take && tx_in_last_i) begin
                    if (need_pad) tx_st_r <= TX_PAD;
                    else if (tx_crc_append_en) tx_st_r <= TX_FCS;
                    else tx_st_r <= TX_IDLE;
                end
                TX_PAD: if (adv && (tx_cnt_r + 7'h01 == pad_target)) begin
                    tx_st_r <= tx_crc_append_en ? TX_FCS : TX_IDLE;
                end
                TX_FCS: if (adv && fcs_idx_r == 2'h3) tx_st_r <= TX_IDLE;
                default: tx_st_r <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i || tx_start) begin
            tx_cnt_r <= 7'h00;
            fcs_idx_r <= 2'h0;
        end else begin
            if ((tx_take || pad_go) && tx_cnt_r != 7'h7f) tx_cnt_r <= tx_cnt_r + 7'h01;
            if (tx_st_r == TX_FCS && adv) fcs_idx_r <= fcs_idx_r + 2'h1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            txo_valid_r <= 1'b0;
            txo_data_r <= 8'h00;
            txo_last_r <= 1'b0;
        end else if (adv) begin
            txo_valid_r <= tx_take || (tx_st_r == TX_PAD) || (tx_st_r == TX_FCS);
            if (tx_take) begin
                txo_data_r <= tx_in_data_i;
                txo_last_r <= tx_in_last_i && !need_pad && !tx_crc_append_en;
            end else if (tx_st_r == TX_PAD) begin
                txo_data_r <= 8'h00;
                txo_last_r <= (tx_cnt_r + 7'h01 == pad_target) && !tx_crc_append_en;
            end else if (tx_st_r == TX_FCS) begin
                txo_data_r <= ~tx_crc[fcs_idx_r*8 +: 8];
                txo_last_r <= (fcs_idx_r == 2'h3);
            end
        end
    end
    assign tx_out_valid_o = txo_valid_r;
    assign tx_out_data_o = txo_data_r;
    assign tx_out_last_o = txo_last_r;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cur_id_r <= '0;
            last_tx_frame_id_r <= '0;
        end else begin
            if (tx_start) cur_id_r <= tx_in_id_i;
            if (tx_done) last_tx_frame_id_r <= cur_id_r;
        end
    end

    // ------------------------------------------------------------
    // Receive filter and CRC handling
    // ------------------------------------------------------------
    logic in_frame_r;
    logic adm_r;
    logic [2:0] rx_cnt_r;
    logic [47:0] da_r;
    logic [31:0] dly_r;
    logic hash_hit_r;
    logic [31:0] rx_crc_nxt;
    logic rxo_valid_r;
    logic [7:0] rxo_data_r;
    logic rxo_last_r;
    logic rxo_keep_r;
    logic addr_ok;
    wire rx_first = rx_in_valid_i && !in_frame_r;
    wire rx_adm = rx_first ? rx_run_en : adm_r;
    wire rx_end = rx_in_valid_i && rx_in_last_i;
    wire crc_ok = (rx_crc_nxt == CRC_RESIDUE);
    wire is_mcast = da_r[0];
    wire is_bcast = (da_r == 48'hffffffffffff);

    hpq_crc32 u_rx_crc (
        .clock_i(clock_i),
        .rst_i(rst_i),
        .clear_i(rx_end),
        .en_i(rx_in_valid_i),
        .data_i(rx_in_data_i),
        .crc_o(),
        .crc_nxt_o(rx_crc_nxt)
    );

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            in_frame_r <= 1'b0;
            adm_r <= 1'b0;
            rx_cnt_r <= 3'h0;
        end else if (rx_in_valid_i) begin
            in_frame_r <= !rx_in_last_i;
            adm_r <= rx_adm;
            rx_cnt_r <= rx_in_last_i ? 3'h0 : (rx_cnt_r == 3'h7 ? 3'h7 : rx_cnt_r + 3'h1);
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            da_r <= '0;
            dly_r <= '0;
            hash_hit_r <= 1'b0;
        end else if (rx_in_valid_i) begin
            dly_r <= {dly_r[23:0], rx_in_data_i};
            if (rx_cnt_r < 3'(DA_BYTES)) da_r[rx_cnt_r*8 +: 8] <= rx_in_data_i;
            if (rx_cnt_r == 3'(DA_BYTES - 1)) hash_hit_r <= hash_r[rx_crc_nxt[31:26]];
        end
    end

    always_comb begin
        addr_ok = rx_promiscuous;
        if (is_bcast && rx_broadcast_accept) addr_ok = 1'b1;
        if (is_mcast && rx_multicast_accept) addr_ok = 1'b1;
        if (is_mcast && rx_hash_en && hash_hit_r) addr_ok = 1'b1;
        if (!is_mcast && rx_unicast_accept && da_r == station_r) addr_ok = 1'b1;
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            rxo_valid_r <= 1'b0;
            rxo_data_r <= 8'h00;
            rxo_last_r <= 1'b0;
            rxo_keep_r <= 1'b0;
        end else begin
            rxo_valid_r <= rx_in_valid_i && rx_adm && (!rx_crc_strip || rx_cnt_r >= 3'(CRC_BYTES));
            rxo_data_r <= rx_crc_strip ? dly_r[31:24] : rx_in_data_i;
            rxo_last_r <= rx_end && rx_adm;
            rxo_keep_r <= rx_end && rx_adm && addr_ok && (crc_ok || rx_crc_error_accept);
        end
    end
    assign rx_out_valid_o = rxo_valid_r;
    assign rx_out_data_o = rxo_data_r;
    assign rx_out_last_o = rxo_last_r;
    assign rx_out_keep_o = rxo_keep_r;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_frame_end;
        rx_end && rx_adm;
    endsequence
    sequence s_tx_tail;
        tx_take && tx_in_last_i && !need_pad;
    endsequence

    chk_pause_req: assert property (@(posedge clock_i) disable iff (rst_i)
        (tx_pause_gen_en && global_pause_en_i && rx_fifo_threshold_i) |=> tx_pause_req_o)
        else $error("pause request missing");
    chk_pad_len: assert property (@(posedge clock_i) disable iff (rst_i)
        (tx_st_r == TX_PAD && adv) |-> (tx_cnt_r < pad_target))
        else $error("padding past minimum length");
    chk_crc_tail: assert property (@(posedge clock_i) disable iff (rst_i)
        (s_tx_tail and tx_crc_append_en) |=> (tx_st_r == TX_FCS))
        else $error("CRC not appended");
    chk_tx_stopped: assert property (@(posedge clock_i) disable iff (rst_i)
        (tx_st_r == TX_IDLE && (!tx_run_en || pause_active)) |=> (tx_st_r == TX_IDLE))
        else $error("transmit started while stopped");
    chk_tx_id: assert property (@(posedge clock_i) disable iff (rst_i)
        tx_done |=> (last_tx_frame_id_r == $past(cur_id_r)))
        else $error("frame id not updated");
    chk_crc_drop: assert property (@(posedge clock_i) disable iff (rst_i)
        (s_frame_end and !crc_ok && !rx_crc_error_accept) |=> (rx_out_last_o && !rx_out_keep_o))
        else $error("bad CRC frame kept");
    chk_promisc_keep: assert property (@(posedge clock_i) disable iff (rst_i)
        (s_frame_end and crc_ok && rx_promiscuous) |=> rx_out_keep_o)
        else $error("promiscuous frame dropped");
    chk_strip_head: assert property (@(posedge clock_i) disable iff (rst_i)
        (rx_in_valid_i && rx_crc_strip && rx_cnt_r < 3'(CRC_BYTES)) |=> !rx_out_valid_o)
        else $error("stripped frame byte emitted early");
    chk_rx_stopped: assert property (@(posedge clock_i) disable iff (rst_i)
        (rx_first && !rx_run_en) |=> !rx_out_valid_o)
        else $error("receive started while stopped");

endmodule : hpq_txrx_ctrl

// >>> hpq_txrx_ctrl_bench.sv
// Self-checking bench of the transmit and receive control block.
// Assumes the host partner model and the design package are compiled first.
`timescale 1ns/1ps
module hpq_txrx_ctrl_bench;
    import hpq_pkg::*;
    logic clock_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, rx_in_data_i = 8'h00, len = 8'h01;
    logic [15:0] reg_wdata_i = 16'h0000, pause_quanta_i = 16'h0000, reg_rdata_o, d;
    logic global_pause_en_i = 1'b0, rx_fifo_threshold_i = 1'b0, pause_rx_i = 1'b0;
    logic rx_in_valid_i = 1'b0, rx_in_last_i = 1'b0, start = 1'b0, stall = 1'b1;
    logic tx_pause_req_o, tx_in_valid_i, tx_in_last_i, tx_in_ready_o, tx_out_valid_o, tx_out_last_o;
    logic tx_out_ready_i, tx_paused_o, rx_out_valid_o, rx_out_last_o, rx_out_keep_o, done, seen, keep;
    logic [7:0] tx_in_data_i, tx_out_data_o, rx_out_data_o, out_cnt;
    logic [5:0] tx_in_id_i, id = 6'h00;
    int error_cnt = 0, cmp_count = 0;
    logic [31:0] txc;
    hpq_txrx_ctrl dut (.clock_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
        .global_pause_en_i, .rx_fifo_threshold_i, .tx_pause_req_o, .tx_in_valid_i, .tx_in_data_i,
        .tx_in_last_i, .tx_in_id_i, .tx_in_ready_o, .tx_out_valid_o, .tx_out_data_o, .tx_out_last_o,
        .tx_out_ready_i, .pause_rx_i, .pause_quanta_i, .tx_paused_o, .rx_in_valid_i, .rx_in_data_i,
        .rx_in_last_i, .rx_out_valid_o, .rx_out_data_o, .rx_out_last_o, .rx_out_keep_o);
    hpq_host_model host (.clock_i, .start_i(start), .len_i(len), .id_i(id), .stall_i(stall),
        .tx_in_ready_i(tx_in_ready_o), .tx_out_valid_i(tx_out_valid_o), .tx_out_last_i(tx_out_last_o),
        .tx_in_valid_o(tx_in_valid_i), .tx_in_data_o(tx_in_data_i), .tx_in_last_o(tx_in_last_i),
        .tx_in_id_o(tx_in_id_i), .tx_out_ready_o(tx_out_ready_i), .out_cnt_o(out_cnt), .done_o(done));
    initial begin
        forever #25 clock_i = ~clock_i;
    end
    always @(posedge clock_i) begin
        if (start) txc <= CRC_INIT;
        else if (tx_out_valid_o && tx_out_ready_i) txc <= crc_step(txc, tx_out_data_o);
    end
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
        for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
        return c;
    endfunction : crc_step
    task automatic stop_test;
        $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [15:0] v);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= v;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask : rd
    task automatic send_wait(input logic [7:0] n, input logic [5:0] fid, input int tmo);
        @(posedge clock_i);
        start <= 1'b1;
        len <= n;
        id <= fid;
        @(posedge clock_i);
        start <= 1'b0;
        @(posedge clock_i);
        for (int i = 0; i < tmo && done !== 1'b1; i++) @(posedge clock_i);
    endtask : send_wait
    task automatic t_regs;
        rd(ADDR_TX_CTRL); chk(d, TX_CTRL_RST);
        rd(ADDR_RX_CTRL); chk(d, RX_CTRL_RST);
        wr(ADDR_TX_CTRL, 16'hffff); rd(ADDR_TX_CTRL); chk(d, TX_CTRL_WMASK);
        wr(ADDR_RX_CTRL, 16'hffff); rd(ADDR_RX_CTRL); chk(d, RX_CTRL_WMASK);
        wr(ADDR_TX_STAT, 16'hffff); rd(ADDR_TX_STAT); chk(d & 16'hffc0, 16'h0000);
        rd(8'h08); chk(d, 16'h0000);
        wr(ADDR_TX_CTRL, 16'h0000);
        wr(ADDR_RX_CTRL, 16'h0000);
        $display("Register test done");
    endtask : t_regs
    task automatic t_pause_gen;
        wr(ADDR_TX_CTRL, 16'h0008);
        global_pause_en_i <= 1'b1;
        rx_fifo_threshold_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1 chk(tx_pause_req_o, 1'b1);
        global_pause_en_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1 chk(tx_pause_req_o, 1'b0);
        wr(ADDR_TX_CTRL, 16'h0000);
        global_pause_en_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        #1 chk(tx_pause_req_o, 1'b0);
        rx_fifo_threshold_i <= 1'b0;
        $display("Pause request test done");
    endtask : t_pause_gen
    task automatic t_tx;
        logic [15:0] ctl [4] = '{16'h0007, 16'h0005, 16'h0003, 16'h0001};
        logic [7:0] n [4] = '{8'd10, 8'd10, 8'd10, 8'd70};
        logic [15:0] e [4] = '{16'd64, 16'd64, 16'd14, 16'd70};
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_TX_CTRL, ctl[i]);
            send_wait(n[i], 6'(i + 3), 400);
            if (done !== 1'b1) begin
                error_cnt++;
                stop_test();
            end
            chk({8'h00, out_cnt}, e[i]);
            if (ctl[i][1]) chk({15'h0000, txc === CRC_RESIDUE}, 16'h0001);
            rd(ADDR_TX_STAT); chk(d, 16'(i + 3));
        end
        wr(ADDR_TX_CTRL, 16'h0006);
        send_wait(8'd10, 6'h2a, 20);
        chk({8'h00, out_cnt}, 16'h0000);
        wr(ADDR_TX_CTRL, 16'h0007);
        for (int i = 0; i < 400 && done !== 1'b1; i++) @(posedge clock_i);
        chk({8'h00, out_cnt}, 16'd64);
        rd(ADDR_TX_STAT); chk(d, 16'h002a);
        if (done !== 1'b1) begin
            error_cnt++;
            stop_test();
        end
        $display("Transmit test done");
    endtask : t_tx
    task automatic t_rx;
        logic [15:0] ctl [10] = '{16'h0281, 16'h0201, 16'h0241, 16'h0221, 16'h0221, 16'h0211, 16'h0011, 16'h0210,
            16'h0019, 16'h0205};
        logic [7:0] da [10] = '{8'hff, 8'hff, 8'hff, 8'h02, 8'h04, 8'h04, 8'h04, 8'hff, 8'h04, 8'h05};
        logic [1:0] e [10] = '{2'b11, 2'b10, 2'b11, 2'b11, 2'b10, 2'b11, 2'b10, 2'b00, 2'b11, 2'b11};
        logic [31:0] c = CRC_INIT;
        logic [7:0] b, last;
        int n;
        for (int j = 0; j < DA_BYTES; j++) c = crc_step(c, 8'h05);
        wr(ADDR_HASH_0 + 8'(c[31:30] * 2), 16'h0001 << c[29:26]);
        wr(ADDR_STA_0, 16'h0202);
        wr(ADDR_STA_1, 16'h0202);
        wr(ADDR_STA_2, 16'h0202);
        for (int i = 0; i < 10; i++) begin
            wr(ADDR_RX_CTRL, ctl[i]);
            c = CRC_INIT;
            n = 0;
            for (int j = 0; j < 16; j++) begin
                b = (j < 12) ? ((j < DA_BYTES) ? da[i] : 8'(j * 7)) : ~c[(j - 12) * 8 +: 8];
                if (j < 12) c = crc_step(c, b);
                if (j == 15 && (i == 5 || i == 6)) b = ~b;
                @(posedge clock_i);
                rx_in_valid_i <= 1'b1;
                rx_in_data_i <= b;
                rx_in_last_i <= (j == 15);
                #1 n += (rx_out_valid_o === 1'b1);
            end
            @(posedge clock_i);
            rx_in_valid_i <= 1'b0;
            rx_in_data_i <= 8'ha5;
            rx_in_last_i <= 1'b0;
            seen = 1'b0;
            keep = 1'b0;
            for (int k = 0; k < 8; k++) begin
                #1 if (rx_out_last_o === 1'b1 && !seen) {seen, keep, last} = {1'b1, rx_out_keep_o, rx_out_data_o};
                n += (rx_out_valid_o === 1'b1);
                @(posedge clock_i);
            end
            chk({14'h0000, seen, keep}, {14'h0000, e[i]});
            chk(16'(n), ctl[i][0] ? (ctl[i][3] ? 16'd12 : 16'd16) : 16'd0);
            if (seen) chk(last, ctl[i][3] ? 8'd77 : b);
        end
        $display("Receive filter test done");
    endtask : t_rx
    task automatic t_pause_rx(input logic [15:0] ctl, input logic exp);
        wr(ADDR_RX_CTRL, ctl);
        @(posedge clock_i);
        pause_rx_i <= 1'b1;
        pause_quanta_i <= 16'h0001;
        @(posedge clock_i);
        pause_rx_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        #1 chk(tx_paused_o, exp);
        repeat (QUANTUM_CYC + 5) @(posedge clock_i);
        #1 chk(tx_paused_o, 1'b0);
        $display("Pause honour test done");
    endtask : t_pause_rx
    initial begin
        repeat (4) @(posedge clock_i);
        rst_i <= 1'b0;
        t_regs();
        t_pause_gen();
        t_tx();
        t_rx();
        t_pause_rx(16'h0400, 1'b1);
        t_pause_rx(16'h0000, 1'b0);
        stop_test();
    end
endmodule : hpq_txrx_ctrl_bench
